// ### include/cfg_hdr_defines.svh
// Offsets, field positions, reset values and constants of the header block
`ifndef CFG_HDR_DEFINES_SVH
`define CFG_HDR_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define CFG_OFS_CMD_STATUS 8'h04
`define CFG_OFS_REV_CLASS 8'h08
`define CFG_OFS_MISC 8'h0C
`define CFG_OFS_BUS_NUMBERS 8'h18

// ****************************************
// Command half field positions
// ****************************************
`define CFG_CMD_PARITY_RESP_BIT 6
`define CFG_CMD_SERR_EN_BIT 8

// ****************************************
// Status half field positions
// ****************************************
`define CFG_ST_INT_PENDING_BIT 19
`define CFG_ST_CAP_LIST_BIT 20
`define CFG_ST_66MHZ_BIT 21
`define CFG_ST_FAST_B2B_BIT 23
`define CFG_ST_MASTER_PARITY_BIT 24
`define CFG_ST_SEL_TIMING_LSB 25
`define CFG_ST_SIG_TGT_ABORT_BIT 27
`define CFG_ST_RCV_TGT_ABORT_BIT 28
`define CFG_ST_RCV_MST_ABORT_BIT 29
`define CFG_ST_SIG_SYS_ERR_BIT 30
`define CFG_ST_DET_PARITY_BIT 31

// ****************************************
// Field positions of the packed words
// ****************************************
`define CFG_REV_LSB 0
`define CFG_CLASS_LSB 8
`define CFG_CACHE_LINE_LSB 0
`define CFG_UP_LAT_LSB 8
`define CFG_LAYOUT_LSB 16
`define CFG_UP_BUS_LSB 0
`define CFG_DOWN_BUS_LSB 8
`define CFG_SUB_BUS_LSB 16
`define CFG_DOWN_LAT_LSB 24

// ****************************************
// Constant field values and reset values
// ****************************************
`define CFG_CLASS_CODE 24'h060400
`define CFG_LAYOUT_TYPE 8'h01
`define CFG_LATENCY_VALUE 8'h00
`define CFG_BYTE_RESET 8'h00
`define CFG_CAP_LIST_VALUE 1'b1
`define CFG_FLAG_COUNT 6

`endif

// ### include/cfg_hdr_pkg.sv
// Types shared by the header register block
package cfg_hdr_pkg;

    typedef logic [7:0] cfg_byte_type;

    typedef logic [31:0] cfg_word_type;

    typedef enum logic [2:0]
    {
        SEL_NONE = 3'h0,
        SEL_CMD_STATUS = 3'h1,
        SEL_REV_CLASS = 3'h3,
        SEL_MISC = 3'h2,
        SEL_BUS_NUMBERS = 3'h6
    } reg_sel_type;

endpackage

// ### hdl/status_flag.sv
// One sticky status flag, set by hardware, optionally write-one-to-clear
module status_flag
#(
    parameter bit CLEARABLE = 1'b1
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Set and clear requests
    input wire logic set,
    input wire logic clear,
    // Flag state
    output logic value
);

    // ****************************************
    // Next value
    // ****************************************
    // The set term is ORed outside the clear mask so a set beside a clear keeps the event
    wire logic clear_allowed = CLEARABLE && clear;
    wire logic next_value = set | (value & ~clear_allowed);

    // ****************************************
    // Flag register
    // ****************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            value <= 1'b0;
        end
        else
        begin
            value <= next_value;
        end
    end

endmodule

// ### hdl/cfg_header_regs.sv
// Bridge configuration header: status, identity, timers, bus numbers
//
// The address-and-strobe port is this design's own decision.
`include "cfg_hdr_defines.svh"

module cfg_header_regs
#(
    parameter int ADDR_WIDTH = 8,
    // Arbitrary neutral revision value
    parameter logic [7:0] SILICON_REVISION = 8'h5A
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,

    // Register port
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,

    // Primary side events, one-cycle pulses
    input wire logic req_parity_error,
    input wire logic abort_completion_sent,
    input wire logic abort_completion_received,
    input wire logic unsupported_completion_received,
    input wire logic error_message_sent,
    input wire logic poisoned_packet_received,

    // Controls for the port core
    output logic parity_response_enable,
    output logic error_report_enable,

    // Bus numbers for routing
    output logic [7:0] upstream_bus_number,
    output logic [7:0] downstream_bus_number,
    output logic [7:0] highest_bus_below
);

    // ****************************************
    // Address decode
    // ****************************************
    // Used by both the write and the read path
    function automatic cfg_hdr_pkg::reg_sel_type decode_addr
    (
        input logic [ADDR_WIDTH-1:0] addr
    );
        logic [7:0] ofs;
        ofs = 8'(addr);
        case (ofs)
            `CFG_OFS_CMD_STATUS: decode_addr = cfg_hdr_pkg::SEL_CMD_STATUS;
            `CFG_OFS_REV_CLASS: decode_addr = cfg_hdr_pkg::SEL_REV_CLASS;
            `CFG_OFS_MISC: decode_addr = cfg_hdr_pkg::SEL_MISC;
            `CFG_OFS_BUS_NUMBERS: decode_addr = cfg_hdr_pkg::SEL_BUS_NUMBERS;
            default: decode_addr = cfg_hdr_pkg::SEL_NONE;
        endcase
    endfunction

    wire cfg_hdr_pkg::reg_sel_type sel = decode_addr(reg_addr);
    // Upper address bits must be zero for a hit
    wire logic addr_in_range = (reg_addr >> 8) == '0;

    wire logic wr_cmd_status = reg_write && addr_in_range &&
        (sel == cfg_hdr_pkg::SEL_CMD_STATUS);
    wire logic wr_misc = reg_write && addr_in_range &&
        (sel == cfg_hdr_pkg::SEL_MISC);
    wire logic wr_bus_numbers = reg_write && addr_in_range &&
        (sel == cfg_hdr_pkg::SEL_BUS_NUMBERS);

    // ****************************************
    // Command enables
    // ****************************************
    wire logic next_parity_response_enable = wr_cmd_status ?
        reg_wdata[`CFG_CMD_PARITY_RESP_BIT] :
        parity_response_enable;
    wire logic next_error_report_enable = wr_cmd_status ?
        reg_wdata[`CFG_CMD_SERR_EN_BIT] :
        error_report_enable;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            parity_response_enable <= 1'b0;
            error_report_enable <= 1'b0;
        end
        else
        begin
            parity_response_enable <= next_parity_response_enable;
            error_report_enable <= next_error_report_enable;
        end
    end

    // ****************************************
    // Status flag set terms
    // ****************************************
    // Parity errors are dropped while response is disabled
    wire logic set_master_parity = req_parity_error &&
        parity_response_enable;
    wire logic set_sig_tgt_abort = abort_completion_sent;
    wire logic set_rcv_tgt_abort = abort_completion_received;
    wire logic set_rcv_mst_abort = unsupported_completion_received;
    wire logic set_sig_sys_err = error_message_sent &&
        error_report_enable;
    wire logic set_det_parity = poisoned_packet_received;

    // ****************************************
    // Status flag table
    // ****************************************
    // Index order: parity, sig abort, rcv abort, rcv master, sys err, poison
    localparam int FLAG_COUNT = `CFG_FLAG_COUNT;
    localparam int FLAG_BIT [FLAG_COUNT] = '{
        `CFG_ST_MASTER_PARITY_BIT,
        `CFG_ST_SIG_TGT_ABORT_BIT,
        `CFG_ST_RCV_TGT_ABORT_BIT,
        `CFG_ST_RCV_MST_ABORT_BIT,
        `CFG_ST_SIG_SYS_ERR_BIT,
        `CFG_ST_DET_PARITY_BIT
    };
    // Abort flags are read-only sticky; only reset clears them
    localparam bit FLAG_CLEARABLE [FLAG_COUNT] = '{
        1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1
    };

    wire logic [FLAG_COUNT-1:0] flag_set = {
        set_det_parity,
        set_sig_sys_err,
        set_rcv_mst_abort,
        set_rcv_tgt_abort,
        set_sig_tgt_abort,
        set_master_parity
    };
    logic [FLAG_COUNT-1:0] flag_value;
    logic [31:0] flag_word;

    // ****************************************
    // Status flags
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < FLAG_COUNT; i++)
        begin : g_flag
            wire logic clear_req = wr_cmd_status &&
                reg_wdata[FLAG_BIT[i]];
            status_flag
            #(
                .CLEARABLE(FLAG_CLEARABLE[i])
            )
            u_flag
            (
                .clk(clk),
                .reset(reset),
                .set(flag_set[i]),
                .clear(clear_req),
                .value(flag_value[i])
            );
        end
    endgenerate

    always_comb
    begin
        flag_word = '0;
        for (int k = 0; k < FLAG_COUNT; k++)
        begin
            flag_word[FLAG_BIT[k]] = flag_value[k];
        end
    end

    // ****************************************
    // Writable byte fields
    // ****************************************
    logic [7:0] cache_line_size;

    wire logic [7:0] next_cache_line_size = wr_misc ?
        reg_wdata[`CFG_CACHE_LINE_LSB +: 8] :
        cache_line_size;
    wire logic [7:0] next_upstream_bus_number = wr_bus_numbers ?
        reg_wdata[`CFG_UP_BUS_LSB +: 8] :
        upstream_bus_number;
    wire logic [7:0] next_downstream_bus_number = wr_bus_numbers ?
        reg_wdata[`CFG_DOWN_BUS_LSB +: 8] :
        downstream_bus_number;
    wire logic [7:0] next_highest_bus_below = wr_bus_numbers ?
        reg_wdata[`CFG_SUB_BUS_LSB +: 8] :
        highest_bus_below;

    // Cache line size is storage only, it feeds nothing but read-back
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cache_line_size <= `CFG_BYTE_RESET;
        end
        else
        begin
            cache_line_size <= next_cache_line_size;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            upstream_bus_number <= `CFG_BYTE_RESET;
            downstream_bus_number <= `CFG_BYTE_RESET;
            highest_bus_below <= `CFG_BYTE_RESET;
        end
        else
        begin
            upstream_bus_number <= next_upstream_bus_number;
            downstream_bus_number <= next_downstream_bus_number;
            highest_bus_below <= next_highest_bus_below;
        end
    end

    // ****************************************
    // Read words
    // ****************************************
    // Constant status bits; other status bits come from the flag table or read zero
    wire logic [31:0] status_const =
        32'(`CFG_CAP_LIST_VALUE) << `CFG_ST_CAP_LIST_BIT;
    // Interrupt pending, legacy speed and timing bits stay zero
    wire logic [31:0] status_zero_mask =
        (32'h1 << `CFG_ST_INT_PENDING_BIT) |
        (32'h1 << `CFG_ST_66MHZ_BIT) |
        (32'h1 << `CFG_ST_FAST_B2B_BIT) |
        (32'h3 << `CFG_ST_SEL_TIMING_LSB);

    wire logic [31:0] command_word =
        (32'(parity_response_enable) << `CFG_CMD_PARITY_RESP_BIT) |
        (32'(error_report_enable) << `CFG_CMD_SERR_EN_BIT);

    // Reserved status bits have no storage, so writes cannot stick
    wire logic [31:0] cmd_status_word = command_word |
        ((status_const | flag_word) & ~status_zero_mask);

    wire logic [31:0] rev_class_word =
        (32'(SILICON_REVISION) << `CFG_REV_LSB) |
        (32'(`CFG_CLASS_CODE) << `CFG_CLASS_LSB);

    wire logic [31:0] misc_word =
        (32'(cache_line_size) << `CFG_CACHE_LINE_LSB) |
        (32'(`CFG_LATENCY_VALUE) << `CFG_UP_LAT_LSB) |
        (32'(`CFG_LAYOUT_TYPE) << `CFG_LAYOUT_LSB);

    wire logic [31:0] bus_numbers_word =
        (32'(upstream_bus_number) << `CFG_UP_BUS_LSB) |
        (32'(downstream_bus_number) << `CFG_DOWN_BUS_LSB) |
        (32'(highest_bus_below) << `CFG_SUB_BUS_LSB) |
        (32'(`CFG_LATENCY_VALUE) << `CFG_DOWN_LAT_LSB);

    // ****************************************
    // Read selection
    // ****************************************
    // Unmapped offsets read zero instead of stalling the master
    wire cfg_hdr_pkg::reg_sel_type read_sel = addr_in_range ?
        sel : cfg_hdr_pkg::SEL_NONE;
    logic [31:0] read_word;

    always_comb
    begin
        case (read_sel)
            cfg_hdr_pkg::SEL_CMD_STATUS: read_word = cmd_status_word;
            cfg_hdr_pkg::SEL_REV_CLASS: read_word = rev_class_word;
            cfg_hdr_pkg::SEL_MISC: read_word = misc_word;
            cfg_hdr_pkg::SEL_BUS_NUMBERS: read_word = bus_numbers_word;
            default: read_word = 32'h00000000;
        endcase
    end

    // ****************************************
    // Read data register
    // ****************************************
    // Data stands for one cycle after the strobe, zero otherwise
    wire logic [31:0] next_reg_rdata = reg_read ? read_word : 32'h00000000;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            reg_rdata <= 32'h00000000;
        end
        else
        begin
            reg_rdata <= next_reg_rdata;
        end
    end

endmodule

// ### verification/cfg_header_regs_assertions.sv
// Concurrent checks on the bridge header register block
module cfg_header_regs_checker
#(
    parameter int ADDR_WIDTH = 8,
    // Arbitrary neutral revision value
    parameter logic [7:0] SILICON_REVISION = 8'h5A
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    // Events
    input wire logic req_parity_error,
    input wire logic abort_completion_sent,
    input wire logic abort_completion_received,
    input wire logic unsupported_completion_received,
    input wire logic error_message_sent,
    input wire logic poisoned_packet_received,
    // Controls and bus numbers
    input wire logic parity_response_enable,
    input wire logic error_report_enable,
    input wire logic [7:0] upstream_bus_number,
    input wire logic [7:0] downstream_bus_number,
    input wire logic [7:0] highest_bus_below
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // Decodes
    // ****************************************
    wire logic rd_status = reg_read && reg_addr == 8'h04;
    wire logic wr_status = reg_write && reg_addr == 8'h04;
    wire logic wr_bus = reg_write && reg_addr == 8'h18;
    wire logic [23:0] buses = {highest_bus_below, downstream_bus_number,
        upstream_bus_number};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // ****************************************
    // Checks
    // ****************************************
    chk_rev_class:
        assert property (reg_read && reg_addr == 8'h08
            |=> reg_rdata == {24'h060400, SILICON_REVISION})
        else $error("revision or class word wrong");
    chk_misc_fixed:
        assert property (reg_read && reg_addr == 8'h0C
            |=> reg_rdata[31:8] == 24'h000100)
        else $error("timer or layout field wrong");
    chk_status_fixed:
        assert property (rd_status
            |=> reg_rdata[23:16] == 8'h10 && reg_rdata[26:25] == 2'h0)
        else $error("fixed status bits wrong");
    chk_bus_readback:
        assert property (reg_read && reg_addr == 8'h18
            |=> reg_rdata == {8'h00, $past(buses)})
        else $error("bus number word wrong");
    chk_bus_write:
        assert property (wr_bus |=> buses == $past(reg_wdata[23:0]))
        else $error("bus numbers not written");
    chk_bus_hold:
        assert property (!wr_bus |=> $stable(buses))
        else $error("bus numbers changed without write");
    chk_enable_write:
        assert property (wr_status
            |=> parity_response_enable == $past(reg_wdata[6])
            && error_report_enable == $past(reg_wdata[8]))
        else $error("command enables not written");
    chk_enable_hold:
        assert property (!wr_status |=> $stable(parity_response_enable)
            && $stable(error_report_enable))
        else $error("command enables changed without write");
    chk_parity_set:
        assert property (req_parity_error && parity_response_enable
            ##1 !reg_write ##1 rd_status |=> reg_rdata[24])
        else $error("master parity flag not set");
    chk_serr_set:
        assert property (error_message_sent && error_report_enable
            ##1 !reg_write ##1 rd_status |=> reg_rdata[30])
        else $error("system error flag not set");
    chk_poison_set:
        assert property (poisoned_packet_received
            ##1 !reg_write ##1 rd_status |=> reg_rdata[31])
        else $error("detected parity flag not set");
    chk_abort_sent:
        assert property (abort_completion_sent
            ##1 !reg_write ##1 rd_status |=> reg_rdata[27])
        else $error("signalled abort flag not set");
    chk_abort_received:
        assert property (abort_completion_received
            ##1 !reg_write ##1 rd_status |=> reg_rdata[28])
        else $error("received abort flag not set");
    chk_unsupported_received:
        assert property (unsupported_completion_received
            ##1 !reg_write ##1 rd_status |=> reg_rdata[29])
        else $error("received master abort flag not set");
    chk_poison_clear:
        assert property (wr_status && reg_wdata[31]
            && !poisoned_packet_received ##1 !poisoned_packet_received
            ##1 rd_status |=> !reg_rdata[31])
        else $error("detected parity flag not cleared");
endmodule

bind cfg_header_regs cfg_header_regs_checker
#(
    .ADDR_WIDTH(ADDR_WIDTH),
    .SILICON_REVISION(SILICON_REVISION)
) u_checker
(
    .clk(clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .req_parity_error(req_parity_error),
    .abort_completion_sent(abort_completion_sent),
    .abort_completion_received(abort_completion_received),
    .unsupported_completion_received(unsupported_completion_received),
    .error_message_sent(error_message_sent),
    .poisoned_packet_received(poisoned_packet_received),
    .parity_response_enable(parity_response_enable),
    .error_report_enable(error_report_enable),
    .upstream_bus_number(upstream_bus_number),
    .downstream_bus_number(downstream_bus_number),
    .highest_bus_below(highest_bus_below)
);

// ### verification/cfg_header_regs_test.sv
// Self-checking bench for the bridge header register block
module cfg_header_regs_test;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // Signals
    // ****************************************
    // Arbitrary revision value
    localparam logic [7:0] REV = 8'h5A;
    logic clk;
    logic reset;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic [5:0] ev;
    logic pre;
    logic ere;
    logic [7:0] ub;
    logic [7:0] db;
    logic [7:0] hb;
    logic [31:0] st;
    int fail_count = 0;
    int n_compared = 0;
    int bitpos [6] = '{24, 27, 28, 29, 30, 31};
    wire logic [31:0] bus_out = {8'h00, hb, db, ub};
    wire logic [31:0] en_out = {30'h0, pre, ere};

    cfg_header_regs #(.SILICON_REVISION(REV)) dut
    (
        .clk(clk),
        .reset(reset),
        .reg_addr(addr),
        .reg_wdata(wdata),
        .reg_write(wr),
        .reg_read(rd),
        .reg_rdata(rdata),
        .req_parity_error(ev[0]),
        .abort_completion_sent(ev[1]),
        .abort_completion_received(ev[2]),
        .unsupported_completion_received(ev[3]),
        .error_message_sent(ev[4]),
        .poisoned_packet_received(ev[5]),
        .parity_response_enable(pre),
        .error_report_enable(ere),
        .upstream_bus_number(ub),
        .downstream_bus_number(db),
        .highest_bus_below(hb)
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Strobes leave a gap cycle so no signal is assigned twice in a step
    task automatic reg_wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand one cycle only, so sample mid-cycle
    task automatic reg_rd(logic [7:0] a, logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check($sformatf("read of %h", a), rdata, exp);
    endtask

    task automatic pulse(int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev <= 6'h00;
    endtask

    task automatic do_reset();
        repeat (4) @(posedge clk);
        reset <= 1'b0;
    endtask

    task automatic check_resets();
        reg_rd(8'h04, 32'h0010_0000);
        reg_rd(8'h08, {24'h060400, REV});
        reg_rd(8'h0C, 32'h0001_0000);
        reg_rd(8'h18, 32'h0000_0000);
        check("bus numbers", bus_out, 32'h0);
        check("enables", en_out, 32'h0);
    endtask

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****************************************
    // Clock, watchdog and tests
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Whole sequence needs about 10 us
    initial
    begin
        #100us;
        fail_count++;
        close_out();
    end

    initial
    begin
        reset = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        ev = 6'h00;
        do_reset();
        check_resets();
        reg_wr(8'h0C, 32'hFFFF_FFFF);
        reg_rd(8'h0C, 32'h0001_00FF);
        reg_wr(8'h08, 32'h0000_0000);
        reg_rd(8'h08, {24'h060400, REV});
        reg_wr(8'h18, 32'hFF30_2010);
        reg_rd(8'h18, 32'h0030_2010);
        check("bus numbers", bus_out, 32'h302010);
        // Unmapped place neither stores nor disturbs
        reg_wr(8'h10, 32'h1234_5678);
        reg_rd(8'h10, 32'h0);
        reg_rd(8'h18, 32'h0030_2010);
        reg_wr(8'h04, 32'hFFFF_FFFF);
        st = 32'h0010_0140;
        reg_rd(8'h04, st);
        check("enables", en_out, 32'h3);
        for (int i = 0; i < 6; i++)
        begin
            pulse(i);
            st[bitpos[i]] = 1'b1;
            reg_rd(8'h04, st);
        end
        reg_wr(8'h04, 32'h0000_0140);
        reg_rd(8'h04, st);
        reg_wr(8'h04, 32'hFFFF_0140);
        st = 32'h3810_0140;
        reg_rd(8'h04, st);
        // Enables off: gated flags must stay clear
        reg_wr(8'h04, 32'h0);
        st = 32'h3810_0000;
        pulse(0);
        pulse(4);
        reg_rd(8'h04, st);
        // Set and clear in one cycle
        @(posedge clk);
        ev[5] <= 1'b1;
        wr <= 1'b1;
        addr <= 8'h04;
        wdata <= 32'h8000_0000;
        @(posedge clk);
        ev <= 6'h00;
        wr <= 1'b0;
        reg_rd(8'h04, 32'hB810_0000);
        reg_wr(8'h04, 32'h8000_0000);
        reg_rd(8'h04, st);
        @(posedge clk);
        reset <= 1'b1;
        do_reset();
        check_resets();
        close_out();
    end
endmodule
